// [src/pps_pkg.sv]
// pps_pkg: register map, reset values and state type of the port pin-select block.
// assumes an AHB-Lite master issuing single word transfers; printed offsets are register indices.
package pps_pkg;

    // printed offsets are not all word aligned, so they are indices: byte address = 4 * index
    localparam logic [29:0] IDX_MSTP_B   = 30'h0008_0014;
    localparam logic [29:0] IDX_PORT0_DIRECTION   = 30'h0008_C000;
    localparam logic [29:0] IDX_PORT3_DIRECTION   = 30'h0008_C003;
    localparam logic [29:0] IDX_PORT0_OUTPUT_DATA    = 30'h0008_C020;
    localparam logic [29:0] IDX_PORT3_OUTPUT_DATA    = 30'h0008_C023;
    localparam logic [29:0] IDX_PORT0_INPUT_BUFFER_CONTROL   = 30'h0008_C060;
    localparam logic [29:0] IDX_IRQ_SEL  = 30'h0008_C108;
    localparam logic [29:0] IDX_SCI_SEL  = 30'h0008_C10F;

    // field positions
    localparam int BIT_EXT_IRQ8_PIN_CHOICE = 0;
    localparam int BIT_SERIAL2_PIN_CHOICE  = 2;
    localparam int BIT_SERIAL2_STOP        = 29;
    localparam int BIT_ICR_PORT0_PIN0      = 0;
    localparam int BIT_ICR_PORT1_PIN2      = 2;

    // reset values: all modules stopped, pins inputs, buffers off, routes on variant a
    localparam logic [31:0] RST_MSTP_B   = 32'hFFFF_FFFF;
    localparam logic [7:0]  RST_BYTE     = 8'h00;

    typedef struct packed {
        logic [31:0] mstp_b;
        logic [7:0]  port0_direction;
        logic [7:0]  port3_direction;
        logic [7:0]  port0_output_data;
        logic [7:0]  port3_output_data;
        logic [7:0]  port0_input_buffer_control;
        logic [7:0]  irq_sel;
        logic [7:0]  sci_sel;
        logic [31:0] hrdata;
        logic        ext_irq;
        logic        rxd;
        logic        tx_out;
        logic        tx_oe;
        logic        clk_en;
    } pps_state_t;

endpackage

// [src/pps_sync.sv]
// pps_sync: two-flop synchroniser for pin inputs.
// assumes inputs are asynchronous to core_clk; only the second stage may be read.
`timescale 1ns/1ps
module pps_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta     <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// [src/pps_ahb_decode.sv]
// pps_ahb_decode: AHB-Lite address phase capture for a zero wait state slave.
// assumes single word transfers; a write's data arrive in the cycle after its address phase.
`timescale 1ns/1ps
module pps_ahb_decode (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    output logic             rd_go,
    output logic      [29:0] rd_idx,
    output logic             wr_go,
    output logic      [29:0] wr_idx
);
    logic accept;

    // htrans[1] covers both NONSEQ and SEQ
    assign accept = hsel && hready && htrans[1];
    assign rd_go  = accept && !hwrite;
    assign rd_idx = haddr[31:2];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_go  <= 1'b0;
            wr_idx <= '0;
        end else if (ce) begin
            wr_go  <= accept && hwrite;
            wr_idx <= haddr[31:2];
        end
    end
endmodule

// [src/pps_top.sv]
// pps_top: port output data and direction, input buffer gating, pin routing for the
// external interrupt line and serial channel two, and serial channel two module stop.
// assumes one AHB-Lite master, pins synchronised here, serial channel logic outside.
// Behaviour
// R1 - output data bits drive their pin level and read back as written
// R2 - direction bit 1 makes the pin an output carrying its data bit
// R3 - interrupt pin choice 0 routes port0 pin0 to external interrupt line a
// R4 - serial pin choice 0 takes serial two receive data from port1 pin2
// R5 - serial pin choice 0 drives serial two transmit data onto port1 pin3
// R6 - input buffer bit 1 lets port0 pin0 or port1 pin2 reach internal logic
// R7 - stop bit 29 at 0 releases serial channel two to run
// R8 - cleared input buffer holds the internal input at its inactive level
`timescale 1ns/1ps
module pps_top (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // pins
    input  wire logic [7:0]  port0_in,
    output logic      [7:0]  port0_out,
    output logic      [7:0]  port0_oe,
    output logic      [7:0]  port3_out,
    output logic      [7:0]  port3_oe,
    input  wire logic        port1_pin2_in,
    output logic             port1_pin3_out,
    output logic             port1_pin3_oe,
    // internal peripherals
    output logic             ext_interrupt_line_a,
    output logic             serial2_rxd,
    input  wire logic        serial2_txd,
    output logic             serial2_clk_en
);
    pps_pkg::pps_state_t st;
    pps_pkg::pps_state_t next_st;

    logic        rd_go;
    logic [29:0] rd_idx;
    logic        wr_go;
    logic [29:0] wr_idx;
    logic [1:0]  pin_sync;

    pps_ahb_decode u_decode (
        .core_clk (core_clk),
        .rstn     (rstn),
        .ce       (ce),
        .hsel     (hsel),
        .haddr    (haddr),
        .htrans   (htrans),
        .hwrite   (hwrite),
        .hready   (hready),
        .rd_go    (rd_go),
        .rd_idx   (rd_idx),
        .wr_go    (wr_go),
        .wr_idx   (wr_idx)
    );

    // only the pins that feed internal logic need a synchroniser
    pps_sync #(
        .WIDTH (2)
    ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .ce       (ce),
        .async_in ({port1_pin2_in, port0_in[0]}),
        .sync_out (pin_sync)
    );

    // unmapped indices read as zero; narrow registers sit in the low byte
    function automatic logic [31:0] read_value(input pps_pkg::pps_state_t s, input logic [29:0] idx);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (idx == pps_pkg::IDX_MSTP_B) begin
            v = s.mstp_b;
        end else if (idx == pps_pkg::IDX_PORT0_DIRECTION) begin
            v = {24'h00_0000, s.port0_direction};
        end else if (idx == pps_pkg::IDX_PORT3_DIRECTION) begin
            v = {24'h00_0000, s.port3_direction};
        end else if (idx == pps_pkg::IDX_PORT0_OUTPUT_DATA) begin
            v = {24'h00_0000, s.port0_output_data};
        end else if (idx == pps_pkg::IDX_PORT3_OUTPUT_DATA) begin
            v = {24'h00_0000, s.port3_output_data};
        end else if (idx == pps_pkg::IDX_PORT0_INPUT_BUFFER_CONTROL) begin
            v = {24'h00_0000, s.port0_input_buffer_control};
        end else if (idx == pps_pkg::IDX_IRQ_SEL) begin
            v = {24'h00_0000, s.irq_sel};
        end else if (idx == pps_pkg::IDX_SCI_SEL) begin
            v = {24'h00_0000, s.sci_sel};
        end
        return v;
    endfunction

    always_comb begin
        next_st = st;
        // register writes land in the data phase
        if (wr_go) begin
            if (wr_idx == pps_pkg::IDX_MSTP_B) begin
                next_st.mstp_b = hwdata;
            end else if (wr_idx == pps_pkg::IDX_PORT0_DIRECTION) begin
                next_st.port0_direction = hwdata[7:0];
            end else if (wr_idx == pps_pkg::IDX_PORT3_DIRECTION) begin
                next_st.port3_direction = hwdata[7:0];
            end else if (wr_idx == pps_pkg::IDX_PORT0_OUTPUT_DATA) begin
                next_st.port0_output_data = hwdata[7:0]; // R1
            end else if (wr_idx == pps_pkg::IDX_PORT3_OUTPUT_DATA) begin
                next_st.port3_output_data = hwdata[7:0]; // R1
            end else if (wr_idx == pps_pkg::IDX_PORT0_INPUT_BUFFER_CONTROL) begin
                next_st.port0_input_buffer_control = hwdata[7:0];
            end else if (wr_idx == pps_pkg::IDX_IRQ_SEL) begin
                next_st.irq_sel = hwdata[7:0];
            end else if (wr_idx == pps_pkg::IDX_SCI_SEL) begin
                next_st.sci_sel = hwdata[7:0];
            end
        end
        // read data sampled from current state so the data phase sees a flop
        if (rd_go) begin
            next_st.hrdata = read_value(st, rd_idx);
        end

        // external interrupt line a: low when buffer off or route not on variant a
        next_st.ext_irq = !st.irq_sel[pps_pkg::BIT_EXT_IRQ8_PIN_CHOICE] // R3
                        && st.port0_input_buffer_control[pps_pkg::BIT_ICR_PORT0_PIN0]          // R6
                        && pin_sync[0];                                    // R8
        // receive idles high, so a gated or unrouted input reads as line idle
        if (!st.sci_sel[pps_pkg::BIT_SERIAL2_PIN_CHOICE]
            && st.port0_input_buffer_control[pps_pkg::BIT_ICR_PORT1_PIN2]) begin
            next_st.rxd = pin_sync[1]; // R4 R6
        end else begin
            next_st.rxd = 1'b1; // R8
        end
        next_st.tx_out = serial2_txd; // R5
        next_st.tx_oe  = !st.sci_sel[pps_pkg::BIT_SERIAL2_PIN_CHOICE]; // R5
        next_st.clk_en = !st.mstp_b[pps_pkg::BIT_SERIAL2_STOP]; // R7
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st.mstp_b  <= pps_pkg::RST_MSTP_B;
            st.port0_direction  <= pps_pkg::RST_BYTE;
            st.port3_direction  <= pps_pkg::RST_BYTE;
            st.port0_output_data   <= pps_pkg::RST_BYTE;
            st.port3_output_data   <= pps_pkg::RST_BYTE;
            st.port0_input_buffer_control  <= pps_pkg::RST_BYTE;
            st.irq_sel <= pps_pkg::RST_BYTE;
            st.sci_sel <= pps_pkg::RST_BYTE;
            st.hrdata  <= 32'h0000_0000;
            st.ext_irq <= 1'b0;
            st.rxd     <= 1'b1;
            st.tx_out  <= 1'b1;
            st.tx_oe   <= 1'b0;
            st.clk_en  <= 1'b0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // zero wait states: the slave is always ready and never errors
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata               = st.hrdata;
    assign port0_out            = st.port0_output_data;   // R1
    assign port0_oe             = st.port0_direction;  // R2
    assign port3_out            = st.port3_output_data;   // R1
    assign port3_oe             = st.port3_direction;  // R2
    assign port1_pin3_out       = st.tx_out;
    assign port1_pin3_oe        = st.tx_oe;
    assign ext_interrupt_line_a = st.ext_irq;
    assign serial2_rxd          = st.rxd;
    assign serial2_clk_en       = st.clk_en;

    property p_p0_data;
        @(posedge core_clk) disable iff (!rstn)
        (ce && wr_go && wr_idx == pps_pkg::IDX_PORT0_OUTPUT_DATA) |=> port0_out == $past(hwdata[7:0]);
    endproperty
    a_p0_data: assert property (p_p0_data) else $error("port0 output does not follow write"); // R1

    property p_p3_data;
        @(posedge core_clk) disable iff (!rstn)
        (ce && wr_go && wr_idx == pps_pkg::IDX_PORT3_OUTPUT_DATA) |=> port3_out == $past(hwdata[7:0]);
    endproperty
    a_p3_data: assert property (p_p3_data) else $error("port3 output does not follow write"); // R1

    property p_readback;
        @(posedge core_clk) disable iff (!rstn)
        (ce && rd_go && rd_idx == pps_pkg::IDX_PORT0_OUTPUT_DATA) |=> hrdata == {24'h00_0000, $past(port0_out)};
    endproperty
    a_readback: assert property (p_readback) else $error("port0 data readback wrong"); // R1

    property p_dir;
        @(posedge core_clk) disable iff (!rstn)
        (ce && wr_go && wr_idx == pps_pkg::IDX_PORT3_DIRECTION) |=> port3_oe == $past(hwdata[7:0]);
    endproperty
    a_dir: assert property (p_dir) else $error("port3 direction does not follow write"); // R2

    property p_irq_route;
        @(posedge core_clk) disable iff (!rstn)
        (ce && !st.irq_sel[0] && st.port0_input_buffer_control[0]) |=> ext_interrupt_line_a == $past(pin_sync[0]);
    endproperty
    a_irq_route: assert property (p_irq_route) else $error("interrupt line not routed from pin"); // R3

    property p_recv_route;
        @(posedge core_clk) disable iff (!rstn)
        (ce && !st.sci_sel[2] && st.port0_input_buffer_control[2]) |=> serial2_rxd == $past(pin_sync[1]);
    endproperty
    a_recv_route: assert property (p_recv_route) else $error("receive data not routed from pin"); // R4

    // sampled rstn keeps the release edge out: the pin enable still shows its reset value one edge later
    property p_tx_route;
        @(posedge core_clk) disable iff (!rstn)
        (ce && rstn && !st.sci_sel[2]) |=> (port1_pin3_oe && port1_pin3_out == $past(serial2_txd));
    endproperty
    a_tx_route: assert property (p_tx_route) else $error("transmit data not driven on pin"); // R5

    property p_buf_off;
        @(posedge core_clk) disable iff (!rstn)
        (ce && !st.port0_input_buffer_control[0] && !st.port0_input_buffer_control[2]) |=> (!ext_interrupt_line_a && serial2_rxd);
    endproperty
    a_buf_off: assert property (p_buf_off) else $error("gated input not at inactive level"); // R6 R8

    property p_stop;
        @(posedge core_clk) disable iff (!rstn)
        ce ##1 ce |-> serial2_clk_en == !$past(st.mstp_b[29]);
    endproperty
    a_stop: assert property (p_stop) else $error("serial two release wrong"); // R7

    property p_p0_dir;
        @(posedge core_clk) disable iff (!rstn)
        (ce && wr_go && wr_idx == pps_pkg::IDX_PORT0_DIRECTION) |=> port0_oe == $past(hwdata[7:0]);
    endproperty
    a_p0_dir: assert property (p_p0_dir) else $error("port0 direction does not follow write"); // R2

    property p_p3_readback;
        @(posedge core_clk) disable iff (!rstn)
        (ce && rd_go && rd_idx == pps_pkg::IDX_PORT3_OUTPUT_DATA) |=> hrdata == {24'h00_0000, $past(port3_out)};
    endproperty
    a_p3_readback: assert property (p_p3_readback) else $error("port3 data readback wrong"); // R1

    property p_p0_dir_readback;
        @(posedge core_clk) disable iff (!rstn)
        (ce && rd_go && rd_idx == pps_pkg::IDX_PORT0_DIRECTION) |=> hrdata == {24'h00_0000, $past(port0_oe)};
    endproperty
    a_p0_dir_readback: assert property (p_p0_dir_readback) else $error("port0 direction readback wrong"); // R2

    property p_p3_dir_readback;
        @(posedge core_clk) disable iff (!rstn)
        (ce && rd_go && rd_idx == pps_pkg::IDX_PORT3_DIRECTION) |=> hrdata == {24'h00_0000, $past(port3_oe)};
    endproperty
    a_p3_dir_readback: assert property (p_p3_dir_readback) else $error("port3 direction readback wrong"); // R2

    // the stop bit lands at the end of the data phase and reaches the enable one edge later
    property p_stop_write;
        @(posedge core_clk) disable iff (!rstn)
        (ce && wr_go && wr_idx == pps_pkg::IDX_MSTP_B) ##1 ce
        |=> serial2_clk_en == !$past(hwdata[pps_pkg::BIT_SERIAL2_STOP], 2);
    endproperty
    a_stop_write: assert property (p_stop_write) else $error("serial two enable does not follow write"); // R7

    property p_irq_gated;
        @(posedge core_clk) disable iff (!rstn)
        (ce && rstn && (st.irq_sel[0] || !st.port0_input_buffer_control[0])) |=> !ext_interrupt_line_a;
    endproperty
    a_irq_gated: assert property (p_irq_gated) else $error("gated interrupt line not low"); // R8

    property p_recv_gated;
        @(posedge core_clk) disable iff (!rstn)
        (ce && rstn && (st.sci_sel[2] || !st.port0_input_buffer_control[2])) |=> serial2_rxd;
    endproperty
    a_recv_gated: assert property (p_recv_gated) else $error("gated receive line not idle"); // R8

    property p_tx_off;
        @(posedge core_clk) disable iff (!rstn)
        (ce && rstn && st.sci_sel[2]) |=> !port1_pin3_oe;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("transmit pin driven off variant a"); // R5

    property p_irq_sel_readback;
        @(posedge core_clk) disable iff (!rstn)
        (ce && rd_go && rd_idx == pps_pkg::IDX_IRQ_SEL) |=> hrdata == {24'h00_0000, $past(st.irq_sel)};
    endproperty
    a_irq_sel_readback: assert property (p_irq_sel_readback) else $error("interrupt select readback wrong"); // R3

    property p_sci_sel_readback;
        @(posedge core_clk) disable iff (!rstn)
        (ce && rd_go && rd_idx == pps_pkg::IDX_SCI_SEL) |=> hrdata == {24'h00_0000, $past(st.sci_sel)};
    endproperty
    a_sci_sel_readback: assert property (p_sci_sel_readback) else $error("serial select readback wrong"); // R4

    property p_icr_readback;
        @(posedge core_clk) disable iff (!rstn)
        (ce && rd_go && rd_idx == pps_pkg::IDX_PORT0_INPUT_BUFFER_CONTROL) |=> hrdata == {24'h00_0000, $past(st.port0_input_buffer_control)};
    endproperty
    a_icr_readback: assert property (p_icr_readback) else $error("input buffer readback wrong"); // R6

    property p_mstp_readback;
        @(posedge core_clk) disable iff (!rstn)
        (ce && rd_go && rd_idx == pps_pkg::IDX_MSTP_B) |=> hrdata == $past(st.mstp_b);
    endproperty
    a_mstp_readback: assert property (p_mstp_readback) else $error("module stop readback wrong"); // R7
endmodule

// [dv/pps_far_side.sv]
// pps_far_side: board side of the pins, a push switch and the far end of the serial link.
// assumes the switch pulls its pin low when pressed and the link line idles high.
`timescale 1ns/1ps
module pps_far_side (
    input  wire logic       sw_pressed,
    input  wire logic       link_on,
    input  wire logic       link_bit,
    output logic      [7:0] port0_in,
    output logic            port1_pin2_in
);
    // unused port0 pins sit on their pull-ups
    assign port0_in      = {7'h7F, ~sw_pressed};
    // a released link rests at its idle mark level
    assign port1_pin2_in = link_on ? link_bit : 1'h1;
endmodule

// [dv/pps_top_tb.sv]
// pps_top_tb: self-checking bench for pps_top, registers over ahb-lite against a model.
// assumes a zero wait state slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module pps_top_tb;
    logic        core_clk, rstn, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  port0_in, port0_out, port0_oe, port3_out, port3_oe;
    logic        port1_pin2_in, port1_pin3_out, port1_pin3_oe;
    logic        ext_interrupt_line_a, serial2_rxd, serial2_txd, serial2_clk_en;
    logic        sw_pressed, link_on, link_bit;
    logic [31:0] addr_of [8];
    logic [31:0] mask_of [8];
    logic [31:0] mdl     [8];
    int          n_fail;
    int          checks;

    pps_top DUT (
        .core_clk(core_clk), .rstn(rstn), .ce(1'h1), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .port0_in(port0_in), .port0_out(port0_out),
        .port0_oe(port0_oe), .port3_out(port3_out), .port3_oe(port3_oe), .port1_pin2_in(port1_pin2_in),
        .port1_pin3_out(port1_pin3_out), .port1_pin3_oe(port1_pin3_oe),
        .ext_interrupt_line_a(ext_interrupt_line_a), .serial2_rxd(serial2_rxd),
        .serial2_txd(serial2_txd), .serial2_clk_en(serial2_clk_en)
    );

    pps_far_side far (
        .sw_pressed(sw_pressed), .link_on(link_on), .link_bit(link_bit),
        .port0_in(port0_in), .port1_pin2_in(port1_pin2_in)
    );

    task automatic summarize();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk_rd(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_pin(input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // the master assumes no fixed latency: it waits for hready under a bound
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'h1 && n < 50);
        if (hreadyout !== 1'h1) begin
            n_fail++;
            summarize();
        end
    endtask

    task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk_pin(8'h00, {7'h0, hresp});
    endtask

    initial begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end

    initial begin
        logic [31:0] v;
        logic [31:0] rd;
        rstn = 1'h0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'h0; hsize = 3'h2; hwdata = 32'h0;
        sw_pressed = 1'h0; link_on = 1'h0; link_bit = 1'h1; serial2_txd = 1'h1;
        n_fail = 0;
        checks = 0;
        addr_of = '{{pps_pkg::IDX_MSTP_B, 2'h0}, {pps_pkg::IDX_PORT0_DIRECTION, 2'h0}, {pps_pkg::IDX_PORT3_DIRECTION, 2'h0},
                    {pps_pkg::IDX_PORT0_OUTPUT_DATA, 2'h0}, {pps_pkg::IDX_PORT3_OUTPUT_DATA, 2'h0}, {pps_pkg::IDX_PORT0_INPUT_BUFFER_CONTROL, 2'h0},
                    {pps_pkg::IDX_IRQ_SEL, 2'h0}, {pps_pkg::IDX_SCI_SEL, 2'h0}};
        for (int k = 0; k < 8; k++) begin
            mask_of[k] = (k == 0) ? 32'hFFFF_FFFF : 32'h0000_00FF;
            mdl[k]     = (k == 0) ? pps_pkg::RST_MSTP_B : {24'h0, pps_pkg::RST_BYTE};
        end
        void'($urandom(31));
        repeat (10) @(posedge core_clk);
        rstn <= 1'h1;
        chk_pin({7'h0, ~pps_pkg::RST_MSTP_B[29]}, {7'h0, serial2_clk_en});
        // reset values first, then random rounds with the stop bit both ways
        for (int r = 0; r < 5; r++) begin
            for (int k = 0; k < 8; k++) begin
                bus(addr_of[k], 1'h0, 32'h0, rd);
                chk_rd(mdl[k], rd);
            end
            chk_pin(mdl[3][7:0], port0_out);
            chk_pin(mdl[4][7:0], port3_out);
            chk_pin(mdl[1][7:0], port0_oe);
            chk_pin(mdl[2][7:0], port3_oe);
            chk_pin({7'h0, ~mdl[0][29]}, {7'h0, serial2_clk_en});
            for (int k = 0; k < 8; k++) begin
                v = $urandom;
                if (k == 0) v[29] = r[0];
                bus(addr_of[k], 1'h1, v, rd);
                mdl[k] = v & mask_of[k];
            end
        end
        // an unmapped word swallows writes and reads as zero
        bus(32'h0000_0100, 1'h1, $urandom, rd);
        bus(32'h0000_0100, 1'h0, 32'h0, rd);
        chk_rd(32'h0, rd);
        // every mix of one shared buffer enable, one shared route choice and the two pin levels
        for (int i = 0; i < 16; i++) begin
            v = $urandom;
            bus(addr_of[5], 1'h1, {24'h0, (v[7:0] & 8'hFA) | {5'h0, i[0], 1'h0, i[0]}}, rd);
            bus(addr_of[6], 1'h1, {24'h0, (v[15:8] & 8'hFE) | {7'h0, i[1]}}, rd);
            bus(addr_of[7], 1'h1, {24'h0, (v[23:16] & 8'hFB) | {5'h0, i[1], 2'h0}}, rd);
            sw_pressed  <= i[2];
            link_on     <= 1'h1;
            link_bit    <= i[3];
            serial2_txd <= v[24];
            repeat (5) @(posedge core_clk);
            @(negedge core_clk);
            chk_pin({7'h0, i[0] & ~i[1] & ~i[2]}, {7'h0, ext_interrupt_line_a});
            chk_pin({7'h0, (i[0] & ~i[1]) ? i[3] : 1'h1}, {7'h0, serial2_rxd});
            chk_pin({7'h0, ~i[1]}, {7'h0, port1_pin3_oe});
            chk_pin({7'h0, v[24]}, {7'h0, port1_pin3_out});
        end
        summarize();
    end
endmodule
